// ==== ars_defines.svh ====
`ifndef ARS_DEFINES_SVH
`define ARS_DEFINES_SVH

// Clock and reset-input filter timing
`define ARS_TCLK_NS 50
`define ARS_TCL_NS 25
`define ARS_FILT_REJECT_NS 50
`define ARS_FILT_ACCEPT_NS 500
`define ARS_FILT_CYC ((`ARS_FILT_REJECT_NS + `ARS_TCLK_NS - 1) / `ARS_TCLK_NS + 1)

// Flash initialization limit and early-read window
`define ARS_FLASH_INIT_NS 1000000
`define ARS_FLASH_INIT_CYC (`ARS_FLASH_INIT_NS / `ARS_TCLK_NS)
`define ARS_FLASH_BLANK_CYC 16'h0040
`define ARS_FLASH_BLANK_DATA 16'hFFFF
`define ARS_FLASH_TRAP_DATA 16'h009B

// Release delay for external boot, in half clock periods
`define ARS_TCL_MIN 4'h3
`define ARS_TCL_SEL_MAX 3'h5

// Restart location
`define ARS_RESET_VECTOR 16'h0000
`define ARS_RESET_SEGMENT 8'h00

`endif

// ==== ars_pkg.sv ====
`include "ars_defines.svh"

package ars_pkg;

  typedef enum logic [2:0] {
    ARS_HOLD,
    ARS_TCL,
    ARS_FLASH,
    ARS_EXIT,
    ARS_RUN
  } ars_state_e;

  // Half-clock-period count rounded up to whole mclk cycles
  function automatic logic [2:0] ars_tcl_cycles(input logic [2:0] sel);
    logic [3:0] n;
    n = 4'h0;
    if (sel > `ARS_TCL_SEL_MAX)
      n = `ARS_TCL_MIN + {1'b0, `ARS_TCL_SEL_MAX};
    else
      n = `ARS_TCL_MIN + {1'b0, sel};
    return 3'((n + 4'h1) >> 1);
  endfunction

endpackage

// ==== ars_filter.sv ====
`timescale 1ns/100ps
`include "ars_defines.svh"

module ars_filter (
  input wire logic mclk, // System clock
  input wire logic arst_n, // Asynchronous reset entry, active low
  input wire logic pin_i, // Raw reset input level
  output logic filt_q // Filtered reset input level
);

  logic [3:0] cnt_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= 4'h0;
      filt_q <= 1'b0;
    end
    else if (pin_i == filt_q)
      cnt_q <= 4'h0;
    else if (cnt_q == 4'(`ARS_FILT_CYC - 1))
    begin
      cnt_q <= 4'h0;
      filt_q <= pin_i;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  filter_stable_a: assert property ($changed(filt_q) |-> ($past(pin_i, 1) == filt_q) && ($past(pin_i, 2) == filt_q))
    else $error("filtered reset changed without two stable samples");

endmodule

// ==== ars_seq.sv ====
`timescale 1ns/100ps
`include "ars_defines.svh"

// Summary of operation
// - Low reset input and low mode enter reset.
// - Reset drives output low, aborts, floats, pulls up.
// - Mode low blocks bidirectional drive on soft resets.
// - Entry works with no running clock.
// - Internal boot waits flash init, at most 1ms.
// - External boot releases after 3..8 half periods.
// - Early flash reads give FFFFh then 009Bh.
// - Flash boot needs no stable oscillator or PLL.
// - Mode falling during low reset also enters.
// - Exit latches config port, strobes go inactive.
// - Fetch restarts at address zero, segment zero.
// - Filter rejects spikes, accepts long pulses.
module ars_seq import ars_pkg::*; #(
  parameter int unsigned FLASH_INIT_CYC = `ARS_FLASH_INIT_CYC
) (
  input wire logic mclk, // System clock, 20 MHz
  input wire logic nrst, // Power-on reset, active low
  input wire logic reset_input_pin_i, // Reset input pin level
  output logic reset_input_pin_o_q, // Reset input pin drive value, always low
  output logic reset_input_pin_oe_q, // Reset input pin pull-down enable
  input wire logic reset_mode_select_pin, // Reset mode pin level
  input wire logic bidir_reset_enable, // Bidirectional reset enabled
  input wire logic sw_wdt_reset_req, // Software or watchdog reset active
  input wire logic external_boot_select, // High: boot from external memory
  input wire logic [2:0] clk_src_sel, // Clock source, sets release delay
  input wire logic flash_init_done, // Flash initialization finished
  input wire logic flash_rd_req, // Flash read strobe
  input wire logic [15:0] flash_data_i, // Flash array data
  output logic [15:0] flash_rdata_q, // Flash read answer
  input wire logic [15:0] config_port_i, // Config port pin levels
  output logic [15:0] system_config_register_q, // Latched start-up configuration
  output logic config_port_pullup_q, // Config port pulled high
  output logic bus_float_q, // Buses and I/O drivers released
  output logic hold_cancel_q, // Pending hold states cancelled
  output logic bus_abort_q, // Bus cycles aborted
  input wire logic cpu_ale, // Address latch strobe from core
  input wire logic cpu_rd_n, // Read strobe from core
  input wire logic cpu_wr_n, // Write strobe from core
  output logic ale_q, // Address latch strobe
  output logic rd_n_q, // Read strobe, active low
  output logic write_strobe_n_q, // Write strobe, active low
  output logic reset_output_pin_q, // Reset output, low in reset
  output logic internal_reset_n_q, // Internal reset, active low
  output logic fetch_start_q, // First fetch request pulse
  output logic [15:0] fetch_addr_q, // First fetch address
  output logic [7:0] fetch_seg_q // First fetch code segment
);

  ars_state_e state_q;
  logic arst_n;
  logic filtered_reset_input;
  logic [2:0] tcl_cnt_q;
  logic [15:0] flash_cnt_q;
  logic [15:0] flash_age_q;
  logic flash_ready_q;
  logic flash_timeout;

  // Entry is purely combinational so it acts with no clock at all. The
  // pin filter guards the synchronous release; a spike on both pins can
  // still enter reset, which is the safe direction.
  assign arst_n = nrst & (reset_input_pin_i | reset_mode_select_pin);

  ars_filter u_filter (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin_i(reset_input_pin_i),
    .filt_q(filtered_reset_input)
  );

  assign flash_timeout = (flash_cnt_q >= 16'(FLASH_INIT_CYC - 1));

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= ARS_HOLD;
    else if (!filtered_reset_input && state_q != ARS_RUN)
      state_q <= ARS_HOLD;
    else
    begin
      unique case (state_q)
        ARS_HOLD:
          if (filtered_reset_input)
            state_q <= external_boot_select ? ARS_TCL : ARS_FLASH;
        ARS_TCL:
          if (tcl_cnt_q <= 3'h1)
            state_q <= ARS_EXIT;
        ARS_FLASH:
          if (flash_init_done || flash_timeout)
            state_q <= ARS_EXIT;
        ARS_EXIT:
          state_q <= ARS_RUN;
        ARS_RUN:
          state_q <= ARS_RUN;
        default:
          state_q <= ARS_HOLD;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      tcl_cnt_q <= 3'h0;
    else if (state_q == ARS_HOLD)
      tcl_cnt_q <= ars_tcl_cycles(clk_src_sel);
    else if (state_q == ARS_TCL)
      tcl_cnt_q <= tcl_cnt_q - 3'h1;
  end

  // Flash runs on its own oscillator, so its wait counts from pin release
  // and does not look at any oscillator or PLL status.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      flash_cnt_q <= 16'h0000;
    else if (state_q == ARS_FLASH && !flash_timeout)
      flash_cnt_q <= flash_cnt_q + 16'h0001;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flash_ready_q <= 1'b0;
      flash_age_q <= 16'h0000;
    end
    else if (filtered_reset_input)
    begin
      if (flash_init_done)
        flash_ready_q <= 1'b1;
      if (flash_age_q != 16'hFFFF)
        flash_age_q <= flash_age_q + 16'h0001;
    end
  end

  // Early reads never reach the array; the trap value makes a premature
  // fetch fail loudly instead of running garbage.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      flash_rdata_q <= `ARS_FLASH_BLANK_DATA;
    else if (flash_rd_req)
    begin
      if (flash_ready_q)
        flash_rdata_q <= flash_data_i;
      else if (flash_age_q < `ARS_FLASH_BLANK_CYC)
        flash_rdata_q <= `ARS_FLASH_BLANK_DATA;
      else
        flash_rdata_q <= `ARS_FLASH_TRAP_DATA;
    end
  end

  // Reset default state: only the exit step lifts it
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reset_output_pin_q <= 1'b0;
      config_port_pullup_q <= 1'b1;
      bus_float_q <= 1'b1;
      hold_cancel_q <= 1'b1;
      bus_abort_q <= 1'b1;
      internal_reset_n_q <= 1'b0;
    end
    else if (state_q == ARS_EXIT)
    begin
      reset_output_pin_q <= 1'b1;
      config_port_pullup_q <= 1'b0;
      bus_float_q <= 1'b0;
      hold_cancel_q <= 1'b0;
      bus_abort_q <= 1'b0;
      internal_reset_n_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ale_q <= 1'b0;
      rd_n_q <= 1'b1;
      write_strobe_n_q <= 1'b1;
    end
    else if (state_q == ARS_RUN)
    begin
      ale_q <= cpu_ale;
      rd_n_q <= cpu_rd_n;
      write_strobe_n_q <= cpu_wr_n;
    end
    else
    begin
      ale_q <= 1'b0;
      rd_n_q <= 1'b1;
      write_strobe_n_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      system_config_register_q <= 16'h0000;
    else if (state_q == ARS_EXIT)
      system_config_register_q <= config_port_i;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fetch_start_q <= 1'b0;
      fetch_addr_q <= `ARS_RESET_VECTOR;
      fetch_seg_q <= `ARS_RESET_SEGMENT;
    end
    else
    begin
      fetch_start_q <= (state_q == ARS_EXIT);
      fetch_addr_q <= `ARS_RESET_VECTOR;
      fetch_seg_q <= `ARS_RESET_SEGMENT;
    end
  end

  // Open-drain pull-down of the reset input on soft resets
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reset_input_pin_o_q <= 1'b0;
      reset_input_pin_oe_q <= 1'b0;
    end
    else
    begin
      reset_input_pin_o_q <= 1'b0;
      reset_input_pin_oe_q <= sw_wdt_reset_req & bidir_reset_enable & reset_mode_select_pin;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence ext_release_s;
    (state_q == ARS_TCL) ##[1:4] (state_q == ARS_EXIT);
  endsequence

  sequence exit_step_s;
    (state_q == ARS_EXIT) ##1 (state_q == ARS_RUN);
  endsequence

  hold_defaults_a: assert property (state_q != ARS_RUN |-> !reset_output_pin_q && bus_float_q && config_port_pullup_q)
    else $error("reset default state not held before release");
  low_input_hold_a: assert property (!filtered_reset_input |=> state_q == ARS_HOLD || state_q == ARS_RUN)
    else $error("release sequencing ran with filtered input low");
  ext_release_a: assert property ((state_q == ARS_HOLD) && filtered_reset_input && external_boot_select |=> ext_release_s)
    else $error("external boot release delay wrong");
  flash_wait_a: assert property ((state_q == ARS_FLASH) && filtered_reset_input && flash_init_done |=> exit_step_s)
    else $error("flash boot did not release after init");
  flash_early_a: assert property (flash_rd_req && !flash_ready_q && (flash_age_q < `ARS_FLASH_BLANK_CYC) |=> flash_rdata_q == 16'hFFFF)
    else $error("early flash read not blank");
  bidir_block_a: assert property (!reset_mode_select_pin |=> !reset_input_pin_oe_q)
    else $error("reset input driven with mode pin low");
  config_latch_a: assert property (state_q == ARS_EXIT |=> (system_config_register_q == $past(config_port_i)) && rd_n_q && write_strobe_n_q && !ale_q)
    else $error("configuration not latched or strobes active at exit");
  fetch_zero_a: assert property (state_q == ARS_EXIT |=> fetch_start_q && (fetch_addr_q == 16'h0000) && (fetch_seg_q == 8'h00) ##1 !fetch_start_q)
    else $error("restart fetch not at location zero");
  release_out_a: assert property (exit_step_s |-> ##1 reset_output_pin_q && internal_reset_n_q && !bus_float_q)
    else $error("outputs not released after exit");

endmodule

// ==== ars_supervisor_model.sv ====
`timescale 1ns/100ps
module ars_supervisor_model (
  input wire logic mclk, // System clock
  input wire logic hold_low, // Command: ground the reset input
  input wire logic mode_low, // Command: pull mode pin low
  input wire logic [7:0] init_after, // Flash init cycles after release, 0 never
  input wire logic pd_oe, // Device pull-down enable
  input wire logic pd_o, // Device pull-down value
  output logic pin, // Resolved reset input level
  output logic mode_pin, // Mode pin level
  output logic init_done, // Flash initialized
  output logic [15:0] flash_data, // Flash array word
  output logic [15:0] cfg // Config port levels
);
  logic [7:0] age_q;
  // Pulled up; the supervisor or the device pull-down may ground it
  assign pin = !(hold_low || (pd_oe && !pd_o));
  assign mode_pin = !mode_low;
  assign cfg = 16'h3A5C;
  assign flash_data = 16'h1234;
  // Flash init has its own oscillator, so it counts from release only
  always_ff @(posedge mclk)
    age_q <= hold_low ? 8'h00 : (age_q == 8'hFF ? age_q : age_q + 8'h01);
  assign init_done = init_after != 8'h00 && age_q >= init_after;
endmodule

// ==== async_reset_sequencer_tb.sv ====
`timescale 1ns/100ps
module async_reset_sequencer_tb import ars_pkg::*;;
  logic mclk = 1'b0, nrst = 1'b0, hold = 1'b1, mode_low = 1'b1, sw = 1'b0, bidir = 1'b0;
  logic ext = 1'b1, rd = 1'b0, ale_i = 1'b0, rdn_i = 1'b1, wrn_i = 1'b1;
  logic [2:0] sel = 3'h0;
  logic [7:0] init_after = 8'h00;
  logic pin, mpin, idone, po, poe, flt, hc, ab, pu, ale, rdn, wrn, ro, irn, fs;
  logic [15:0] fdat, cfg, rdat, scr, fa;
  logic [7:0] fsg;
  int n_fail = 0, checks_done = 0, k;
  always #25 mclk = ~mclk;
  ars_seq #(.FLASH_INIT_CYC(20)) i_dut (.mclk(mclk), .nrst(nrst), .reset_input_pin_i(pin),
    .reset_input_pin_o_q(po), .reset_input_pin_oe_q(poe), .reset_mode_select_pin(mpin),
    .bidir_reset_enable(bidir), .sw_wdt_reset_req(sw), .external_boot_select(ext),
    .clk_src_sel(sel), .flash_init_done(idone), .flash_rd_req(rd), .flash_data_i(fdat),
    .flash_rdata_q(rdat), .config_port_i(cfg), .system_config_register_q(scr),
    .config_port_pullup_q(pu), .bus_float_q(flt), .hold_cancel_q(hc), .bus_abort_q(ab),
    .cpu_ale(ale_i), .cpu_rd_n(rdn_i), .cpu_wr_n(wrn_i), .ale_q(ale), .rd_n_q(rdn),
    .write_strobe_n_q(wrn), .reset_output_pin_q(ro), .internal_reset_n_q(irn),
    .fetch_start_q(fs), .fetch_addr_q(fa), .fetch_seg_q(fsg));
  ars_supervisor_model i_sup (.mclk(mclk), .hold_low(hold), .mode_low(mode_low),
    .init_after(init_after), .pd_oe(poe), .pd_o(po), .pin(pin), .mode_pin(mpin),
    .init_done(idone), .flash_data(fdat), .cfg(cfg));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [15:0] outs();
    return {ro, irn, flt, hc, ab, pu, ale, rdn, wrn};
  endfunction
  // Hold well past the 500ns filter minimum, 10 cycles at this clock
  task automatic enter_rst(input logic e, input logic [2:0] s);
    @(posedge mclk);
    rd <= 1'b0;
    hold <= 1'b1;
    mode_low <= 1'b1;
    ext <= e;
    sel <= s;
    repeat (12) @(posedge mclk);
    #1 chk("defaults", outs(), 16'h007B);
  endtask
  task automatic release_cnt();
    @(posedge mclk);
    hold <= 1'b0;
    k = 0;
    while (irn !== 1'b1 && k < 100)
    begin
      @(posedge mclk);
      #1 k++;
    end
    if (k >= 100)
    begin
      chk("release timeout", 16'h0000, 16'h0001);
      conclude();
    end
  endtask
  task automatic flash_read(input logic [15:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    #1 chk("flash rdata", rdat, exp);
  endtask
  task automatic ext_boot();
    int s;
    for (int i = 0; i < 8; i++)
    begin
      enter_rst(1'b1, 3'(i));
      release_cnt();
      s = (i > 5) ? 5 : i;
      chk("ext release cycles", 16'(k), 16'(4 + (4 + s) / 2));
      chk("released outs", outs(), 16'h0183);
      chk("config latch", scr, 16'h3A5C);
      chk("fetch", {fs, fsg, fa[6:0]}, 16'h8000);
      chk("fetch addr", fa, 16'h0000);
      @(posedge mclk);
      #1 chk("fetch pulse", 16'(fs), 16'h0000);
      if (i == 0)
      begin
        flash_read(16'hFFFF);
        repeat (70) @(posedge mclk);
        flash_read(16'h009B);
      end
    end
  endtask
  task automatic run_checks();
    @(posedge mclk);
    ale_i <= 1'b1;
    rdn_i <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("strobes follow", {ale, rdn}, 16'h0002);
    ale_i <= 1'b0;
    rdn_i <= 1'b1;
    mode_low <= 1'b0;
    @(posedge mclk);
    hold <= 1'b1;
    @(posedge mclk);
    hold <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("spike ignored", 16'(irn), 16'h0001);
    sw <= 1'b1;
    bidir <= 1'b1;
    mode_low <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("bidir blocked", 16'(poe), 16'h0000);
    hold <= 1'b1;
    mode_low <= 1'b0;
    sw <= 1'b0;
    repeat (3) @(posedge mclk);
    mode_low <= 1'b1;
    #1 chk("mode fall entry", outs(), 16'h007B);
    enter_rst(1'b1, 3'h0);
    release_cnt();
    sw <= 1'b1;
    mode_low <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("bidir drive", {poe, po}, 16'h0002);
    sw <= 1'b0;
  endtask
  task automatic int_boot();
    init_after <= 8'd10;
    enter_rst(1'b0, 3'h0);
    release_cnt();
    chk("flash wait", 16'(k > 10 && k <= 16), 16'h0001);
    flash_read(16'h1234);
    init_after <= 8'd0;
    enter_rst(1'b0, 3'h0);
    release_cnt();
    chk("flash timeout", 16'(k >= 20 && k <= 30), 16'h0001);
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    #1 chk("power-on defaults", outs(), 16'h007B);
    ext_boot();
    run_checks();
    int_boot();
    conclude();
  end
endmodule
